// File: logic/region_decode.sv
// Address region decoder for the serial register space
`timescale 1ns/1ps
module region_decode (
    input  wire logic [14:0]               addr,
    output serial_cfg_pkg::region_type     region
);

    // ****************************************
    // Region match
    // ****************************************
    // Unlisted addresses land in REGION_NONE; the region decode does not gate writes
    always_comb begin
        if (addr >= serial_cfg_pkg::IFACE_LO && addr <= serial_cfg_pkg::IFACE_HI) begin
            region = serial_cfg_pkg::REGION_IFACE;
        end else if (addr >= serial_cfg_pkg::CLKPIN_LO && addr <= serial_cfg_pkg::CLKPIN_HI) begin
            region = serial_cfg_pkg::REGION_CLKPIN;
        end else if (addr >= serial_cfg_pkg::FDET_LO && addr <= serial_cfg_pkg::FDET_HI) begin
            region = serial_cfg_pkg::REGION_FDET;
        end else if (addr >= serial_cfg_pkg::DDC_LO && addr <= serial_cfg_pkg::DDC_HI) begin
            region = serial_cfg_pkg::REGION_DDC;
        end else begin
            region = serial_cfg_pkg::REGION_NONE;
        end
    end

endmodule : region_decode

// File: logic/serial_cfg_regs.sv
// Three-wire serial port with configuration register A and output mode register
`timescale 1ns/1ps
module serial_cfg_regs #(
    parameter int SRST_WAIT_CYC = serial_cfg_pkg::SRST_WAIT_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       sclk,
    input  wire logic                       csn,
    input  wire logic                       sdio_i,
    output logic                            sdio_o,
    output logic                            sdio_oe,
    output logic                            lsb_first,
    output logic                            addr_ascend,
    output logic [7:0]                      out_mode,
    output logic                            soft_reset,
    output logic                            boot_busy,
    output serial_cfg_pkg::region_type      region
);

    // ****************************************
    // Declarations
    // ****************************************
    serial_cfg_pkg::port_state_type state_ff;
    logic        sclk_q_ff;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [3:0]  bit_cnt_ff;
    logic [15:0] instr_ff;
    logic [15:0] nxt_instr;
    logic [14:0] addr_ff;
    logic [14:0] nxt_addr;
    logic        read_ff;
    logic [7:0]  rx_ff;
    logic [7:0]  nxt_rx;
    logic [7:0]  tx_ff;
    logic [7:0]  rd_data;
    logic        wr_commit;
    logic        lsb_first_ff;
    logic        ascend_ff;
    logic [7:0]  out_mode_ff;
    logic        srst_ff;
    logic        sdio_o_ff;
    logic        sdio_oe_ff;
    logic [16:0] boot_cnt_ff;
    logic        srst_req;
    serial_cfg_pkg::region_type wr_region;

    // ****************************************
    // Serial clock edges
    // ****************************************
    // Pins are already synchronous, so one stage suffices for edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_q_ff <= 1'b0;
        end else begin
            sclk_q_ff <= sclk;
        end
    end

    assign sclk_rise = sclk & ~sclk_q_ff & ~csn;
    assign sclk_fall = ~sclk & sclk_q_ff & ~csn;

    // Shift-in values honour the selected bit order
    always_comb begin
        if (lsb_first_ff) begin
            nxt_instr = {sdio_i, instr_ff[15:1]};
            nxt_rx    = {sdio_i, rx_ff[7:1]};
        end else begin
            nxt_instr = {instr_ff[14:0], sdio_i};
            nxt_rx    = {rx_ff[6:0], sdio_i};
        end
    end

    // Address for the next byte of a multibyte transfer
    // step direction from ascension bit
    assign nxt_addr = ascend_ff ? addr_ff + 15'h0001 : addr_ff - 15'h0001;

    // Write happens on the eighth data bit of a write frame
    assign wr_commit = sclk_rise && (state_ff == serial_cfg_pkg::DATA_ST) && !read_ff
                       && (bit_cnt_ff == 4'(serial_cfg_pkg::BYTE_BITS - 1));

    // ****************************************
    // Frame sequencer
    // ****************************************
    // A soft reset drops the frame; the port waits for chip select to rise
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= serial_cfg_pkg::IDLE_ST;
            bit_cnt_ff <= 4'h0;
            instr_ff   <= 16'h0000;
            addr_ff    <= 15'h0000;
            read_ff    <= 1'b0;
            rx_ff      <= 8'h00;
        end else if (srst_ff) begin
            state_ff   <= csn ? serial_cfg_pkg::IDLE_ST : serial_cfg_pkg::ABORT_ST;
            bit_cnt_ff <= 4'h0;
            read_ff    <= 1'b0;
        end else if (csn) begin
            state_ff   <= serial_cfg_pkg::IDLE_ST;
            bit_cnt_ff <= 4'h0;
        end else begin
            case (state_ff)
                serial_cfg_pkg::IDLE_ST: begin
                    state_ff   <= serial_cfg_pkg::INSTR_ST;
                    bit_cnt_ff <= 4'h0;
                end
                serial_cfg_pkg::INSTR_ST: begin
                    if (sclk_rise) begin
                        instr_ff   <= nxt_instr;
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == 4'(serial_cfg_pkg::INSTR_BITS - 1)) begin
                            state_ff   <= serial_cfg_pkg::DATA_ST;
                            bit_cnt_ff <= 4'h0;
                            // Read flag sits in bit 15 in either bit order
                            read_ff    <= lsb_first_ff ? nxt_instr[15] : nxt_instr[15];
                            addr_ff    <= lsb_first_ff ? nxt_instr[14:0] : nxt_instr[14:0];
                        end
                    end
                end
                serial_cfg_pkg::DATA_ST: begin
                    if (sclk_rise) begin
                        rx_ff <= nxt_rx;
                        if (bit_cnt_ff == 4'(serial_cfg_pkg::BYTE_BITS - 1)) begin
                            bit_cnt_ff <= 4'h0;
                            addr_ff    <= nxt_addr;
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                serial_cfg_pkg::ABORT_ST: begin
                    state_ff <= serial_cfg_pkg::ABORT_ST;
                end
                default: begin
                    state_ff <= serial_cfg_pkg::IDLE_ST;
                end
            endcase
        end
    end

    // ****************************************
    // Register write path
    // ****************************************
    region_decode u_region_decode (
        .addr   (addr_ff),
        .region (wr_region)
    );

    // Either soft reset bit requests the reset
    // bit 0 duplicates bit 7
    assign srst_req = wr_commit && (addr_ff == serial_cfg_pkg::CFG_A_ADDR)
                      && (nxt_rx[serial_cfg_pkg::SRST_MIRROR_BIT]
                          || nxt_rx[serial_cfg_pkg::SRST_BIT]);

    // Soft reset pulse, never stored as a readable bit
    // self-clearing, writing 0 does nothing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            srst_ff <= 1'b0;
        end else begin
            srst_ff <= srst_req;
        end
    end

    // Configuration register A; mirrored pairs share one flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lsb_first_ff <= serial_cfg_pkg::LSB_FIRST_RST;
            ascend_ff    <= serial_cfg_pkg::ASCEND_RST;
        end else if (srst_ff) begin
            lsb_first_ff <= serial_cfg_pkg::LSB_FIRST_RST;
            ascend_ff    <= serial_cfg_pkg::ASCEND_RST;
        end else if (wr_commit && addr_ff == serial_cfg_pkg::CFG_A_ADDR && !srst_req) begin
            lsb_first_ff <= nxt_rx[serial_cfg_pkg::LSB_MIRROR_BIT]
                            | nxt_rx[serial_cfg_pkg::LSB_BIT];
            ascend_ff    <= nxt_rx[serial_cfg_pkg::ASC_MIRROR_BIT]
                            | nxt_rx[serial_cfg_pkg::ASC_BIT];
        end
    end

    // Output sample mode register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_mode_ff <= serial_cfg_pkg::OUT_MODE_RST;
        end else if (srst_ff) begin
            out_mode_ff <= serial_cfg_pkg::OUT_MODE_RST;
        end else if (wr_commit && addr_ff == serial_cfg_pkg::OUT_MODE_ADDR) begin
            out_mode_ff <= nxt_rx;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Unimplemented locations read as zero
    always_comb begin
        rd_data = 8'h00;
        if (addr_ff == serial_cfg_pkg::CFG_A_ADDR) begin
            // bits 4:3 and reset bits read 0
            rd_data[serial_cfg_pkg::LSB_MIRROR_BIT] = lsb_first_ff;
            rd_data[serial_cfg_pkg::LSB_BIT]        = lsb_first_ff;
            rd_data[serial_cfg_pkg::ASC_MIRROR_BIT] = ascend_ff;
            rd_data[serial_cfg_pkg::ASC_BIT]        = ascend_ff;
        end else if (addr_ff == serial_cfg_pkg::OUT_MODE_ADDR) begin
            rd_data = out_mode_ff;
        end
    end

    // Drive data on falling edges so the host samples on the rising one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_ff      <= 8'h00;
            sdio_o_ff  <= 1'b0;
            sdio_oe_ff <= 1'b0;
        end else if (csn || srst_ff || state_ff != serial_cfg_pkg::DATA_ST || !read_ff) begin
            sdio_oe_ff <= 1'b0;
        end else if (sclk_fall) begin
            sdio_oe_ff <= 1'b1;
            if (bit_cnt_ff == 4'h0) begin
                tx_ff     <= lsb_first_ff ? {1'b0, rd_data[7:1]} : {rd_data[6:0], 1'b0};
                sdio_o_ff <= lsb_first_ff ? rd_data[0] : rd_data[7];
            end else begin
                tx_ff     <= lsb_first_ff ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
                sdio_o_ff <= lsb_first_ff ? tx_ff[0] : tx_ff[7];
            end
        end
    end

    // ****************************************
    // Recovery window after soft reset
    // ****************************************
    // Flags the wait the host owes; writes are not blocked by it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_cnt_ff <= 17'h00000;
        end else if (srst_ff) begin
            boot_cnt_ff <= 17'(SRST_WAIT_CYC);
        end else if (boot_cnt_ff != 17'h00000) begin
            boot_cnt_ff <= boot_cnt_ff - 17'h00001;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sdio_o      = sdio_o_ff;
    assign sdio_oe     = sdio_oe_ff;
    assign lsb_first   = lsb_first_ff;
    assign addr_ascend = ascend_ff;
    assign out_mode    = out_mode_ff;
    assign soft_reset  = srst_ff;
    assign boot_busy   = boot_cnt_ff != 17'h00000;
    assign region      = wr_region;

endmodule : serial_cfg_regs

// File: pkg/serial_cfg_pkg.sv
// Constants, field positions and types for the serial configuration register block
// What this block does
// - Bit 7 write-one resets port, self-clears
// - Reset loads registers with default values
// - Bit 6 picks LSB-first shift, resets 0
// - Bits 5/2 pick address increment, reset 0
// - Decode interface and clock/pin control regions
// - Decode fast detect and downconverter regions
// - Output sample mode register resets to 0x01
// - Bit 0 mirrors bit 7 soft reset
package serial_cfg_pkg;

    // ****************************************
    // Address map
    // ****************************************
    localparam int         ADDR_W         = 15;
    localparam logic [14:0] CFG_A_ADDR    = 15'h0000;
    localparam logic [14:0] OUT_MODE_ADDR = 15'h0561;

    // Region bounds
    localparam logic [14:0] IFACE_LO      = 15'h0000;
    localparam logic [14:0] IFACE_HI      = 15'h000f;
    localparam logic [14:0] CLKPIN_LO     = 15'h003f;
    localparam logic [14:0] CLKPIN_HI     = 15'h0201;
    localparam logic [14:0] FDET_LO       = 15'h0245;
    localparam logic [14:0] FDET_HI       = 15'h027a;
    localparam logic [14:0] DDC_LO        = 15'h0300;
    localparam logic [14:0] DDC_HI        = 15'h03cd;

    // ****************************************
    // Configuration register A fields
    // ****************************************
    localparam int SRST_MIRROR_BIT = 7;
    localparam int LSB_MIRROR_BIT  = 6;
    localparam int ASC_MIRROR_BIT  = 5;
    localparam int ASC_BIT         = 2;
    localparam int LSB_BIT         = 1;
    localparam int SRST_BIT        = 0;

    // Reset values
    localparam logic        LSB_FIRST_RST = 1'b0;
    localparam logic        ASCEND_RST    = 1'b0;
    localparam logic [7:0]  OUT_MODE_RST  = 8'h01;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ        = 20_000_000;
    localparam int SRST_WAIT_MS  = 5;
    localparam int SRST_WAIT_CYC = CLK_HZ / 1000 * SRST_WAIT_MS;

    // Frame layout
    localparam int INSTR_BITS = 16;
    localparam int BYTE_BITS  = 8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        REGION_NONE,
        REGION_IFACE,
        REGION_CLKPIN,
        REGION_FDET,
        REGION_DDC
    } region_type;

    typedef enum logic [1:0] {
        IDLE_ST,
        INSTR_ST,
        DATA_ST,
        ABORT_ST
    } port_state_type;

endpackage : serial_cfg_pkg

// File: sim/spi_config_register_map_chk.sv
// Port-level checks for the configuration register block
`timescale 1ns/1ps
module spi_config_register_map_chk #(
    parameter int SRST_WAIT_CYC = 20
) (
    input wire logic                       clk,
    input wire logic                       resetn,
    input wire logic                       sclk,
    input wire logic                       csn,
    input wire logic                       sdio_i,
    input wire logic                       sdio_o,
    input wire logic                       sdio_oe,
    input wire logic                       lsb_first,
    input wire logic                       addr_ascend,
    input wire logic [7:0]                 out_mode,
    input wire logic                       soft_reset,
    input wire logic                       boot_busy,
    input wire serial_cfg_pkg::region_type region
);
    logic [31:0] busy_cnt_ff;
    logic [31:0] nxt_busy_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Boot window length, counted so a long wait needs no repetition
    assign nxt_busy_cnt = boot_busy ? busy_cnt_ff + 32'h1 : 32'h0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_ff <= 32'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    pulse_one_cycle_a: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset pulse longer than one cycle");
    srst_in_frame_a: assert property (soft_reset |-> !csn)
        else $error("soft reset outside a frame");
    srst_defaults_a: assert property (soft_reset |-> ##[1:2]
        (!lsb_first && !addr_ascend && out_mode == 8'h01))
        else $error("defaults not restored after soft reset");
    srst_busy_a: assert property (soft_reset |-> ##[0:1] boot_busy)
        else $error("boot window not opened");
    busy_len_a: assert property ($fell(boot_busy) |-> busy_cnt_ff == SRST_WAIT_CYC)
        else $error("boot window length wrong");
    reset_values_a: assert property ($rose(resetn) |->
        (out_mode == 8'h01 && !lsb_first && !addr_ascend))
        else $error("wrong values after reset");
    lsb_framed_a: assert property ($changed(lsb_first) |-> !csn)
        else $error("shift order changed outside a frame");
    asc_framed_a: assert property ($changed(addr_ascend) |-> !csn)
        else $error("address step changed outside a frame");
    mode_framed_a: assert property ($changed(out_mode) |-> !csn)
        else $error("output mode changed outside a frame");
    region_hold_a: assert property (csn [*3] |-> $stable(region))
        else $error("region moved while deselected");
    oe_release_a: assert property (csn [*3] |-> !sdio_oe)
        else $error("data line driven while deselected");
endmodule : spi_config_register_map_chk

// File: sim/spi_host_model.sv
// Behavioural serial host that frames reads and writes on the config port
`timescale 1ns/1ps
module spi_host_model #(
    parameter int SETTLE_CYC = 24
) (
    input  wire logic clk,
    input  wire logic sdio_line,
    output logic      sclk,
    output logic      csn,
    output logic      host_oe,
    output logic      host_d
);
    int half_cyc = 3;

    // Link idles deselected with the serial clock parked low
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        host_oe = 1'b0;
        host_d = 1'b0;
    end

    // Pins move a little after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                        input logic lsb, output logic [7:0] rdata);
        logic [15:0] instr;
        int          k;
        instr = {rd, addr};
        rdata = 8'h00;
        csn = 1'b0;
        host_oe = 1'b1;
        tick(half_cyc);
        for (k = 0; k < 24; k++) begin
            sclk = 1'b0;
            // Line released for the read byte so the device can answer
            host_oe = !(rd && k >= 16);
            if (k < 16) begin
                host_d = lsb ? ((k < 15) ? addr[k] : rd) : instr[15-k];
            end else begin
                host_d = lsb ? wdata[k-16] : wdata[23-k];
            end
            tick(half_cyc);
            sclk = 1'b1;
            if (rd && k >= 16) begin
                rdata[lsb ? k-16 : 23-k] = sdio_line;
            end
            tick(half_cyc);
        end
        // Select held past the last edge so the commit lands in frame
        tick(8);
        csn = 1'b1;
        sclk = 1'b0;
        host_oe = 1'b0;
        tick(half_cyc);
    endtask : xfer

    // quiet time after a soft reset
    task automatic settle();
        tick(SETTLE_CYC);
    endtask : settle
endmodule : spi_host_model

// File: sim/test_spi_config_register_map.sv
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module test_spi_config_register_map;
    localparam int WAIT_CYC = 20;
    typedef struct packed {
        logic [14:0]                addr;
        serial_cfg_pkg::region_type reg_exp;
    } row_type;
    logic                       clk;
    logic                       resetn;
    logic                       sclk;
    logic                       csn;
    logic                       sdio_i;
    logic                       sdio_o;
    logic                       sdio_oe;
    logic                       lsb_first;
    logic                       addr_ascend;
    logic                       soft_reset;
    logic                       boot_busy;
    logic                       host_oe;
    logic                       host_d;
    logic [7:0]                 out_mode;
    logic [7:0]                 rd;
    serial_cfg_pkg::region_type region;
    serial_cfg_pkg::region_type seen_region;
    int                         fail_count = 0;
    int                         n_compared = 0;
    int                         srst_seen = 0;
    row_type rows [11] = '{
        '{15'h0000, serial_cfg_pkg::REGION_IFACE}, '{15'h000f, serial_cfg_pkg::REGION_IFACE},
        '{15'h0010, serial_cfg_pkg::REGION_NONE}, '{15'h003f, serial_cfg_pkg::REGION_CLKPIN},
        '{15'h0201, serial_cfg_pkg::REGION_CLKPIN}, '{15'h0202, serial_cfg_pkg::REGION_NONE},
        '{15'h0245, serial_cfg_pkg::REGION_FDET}, '{15'h027a, serial_cfg_pkg::REGION_FDET},
        '{15'h0300, serial_cfg_pkg::REGION_DDC}, '{15'h03cd, serial_cfg_pkg::REGION_DDC},
        '{15'h03ce, serial_cfg_pkg::REGION_NONE}};

    // Shared data line; undriven it shows the inverse of the host's last bit
    assign sdio_i = sdio_oe ? sdio_o : (host_oe ? host_d : !host_d);

    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end

    // Region is caught as the read byte starts, before the address steps
    always @(posedge sdio_oe) seen_region = region;
    always @(posedge clk) if (soft_reset === 1'b1) srst_seen++;

    serial_cfg_regs #(.SRST_WAIT_CYC(WAIT_CYC)) u_serial_cfg_regs (
        .clk(clk), .resetn(resetn), .sclk(sclk), .csn(csn), .sdio_i(sdio_i),
        .sdio_o(sdio_o), .sdio_oe(sdio_oe), .lsb_first(lsb_first),
        .addr_ascend(addr_ascend), .out_mode(out_mode), .soft_reset(soft_reset),
        .boot_busy(boot_busy), .region(region));
    spi_host_model #(.SETTLE_CYC(WAIT_CYC + 4)) u_spi_host_model (
        .clk(clk), .sdio_line(sdio_i), .sclk(sclk), .csn(csn), .host_oe(host_oe),
        .host_d(host_d));

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : check_bit
    task automatic check_region(input string what, input serial_cfg_pkg::region_type exp,
                                input serial_cfg_pkg::region_type got);
        check_byte(what, {5'h00, exp}, {5'h00, got});
    endtask : check_region
    task automatic frame(input logic r, input logic [14:0] a, input logic [7:0] d, input logic l);
        u_spi_host_model.xfer(r, a, d, l, rd);
    endtask : frame
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end

    initial begin
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        #2 resetn = 1'b1;
        @(posedge clk);
        #2;
        check_byte("out_mode", 8'h01, out_mode);
        check_bit("lsb_first", 1'b0, lsb_first);
        check_bit("addr_ascend", 1'b0, addr_ascend);
        // Region sweep at varied host speeds; unmapped places read zero
        foreach (rows[i]) begin
            u_spi_host_model.half_cyc = 3 + i % 3;
            frame(1'b1, rows[i].addr, 8'h00, 1'b0);
            check_region("region", rows[i].reg_exp, seen_region);
            check_byte("read", 8'h00, rd);
        end
        // Reserved bits left zero as the host owes; they must still read zero
        frame(1'b0, 15'h0000, 8'h24, 1'b0);
        check_bit("addr_ascend", 1'b1, addr_ascend);
        frame(1'b1, 15'h0000, 8'h00, 1'b0);
        check_byte("cfg_a", 8'h24, rd);
        // Rising step carries the frame address past the interface region
        frame(1'b1, 15'h000f, 8'h00, 1'b0);
        check_region("stepped", serial_cfg_pkg::REGION_NONE, region);
        // Lower copy alone sets shift order and clears the step
        frame(1'b0, 15'h0000, 8'h02, 1'b0);
        check_bit("lsb_first", 1'b1, lsb_first);
        check_bit("addr_ascend", 1'b0, addr_ascend);
        frame(1'b0, 15'h0561, 8'h00, 1'b1);
        check_byte("out_mode", 8'h00, out_mode);
        frame(1'b1, 15'h0000, 8'h00, 1'b1);
        check_byte("cfg_a", 8'h42, rd);
        // Bit 0 soft reset sent LSB first
        frame(1'b0, 15'h0000, 8'h01, 1'b1);
        check_bit("boot_busy", 1'b1, boot_busy);
        check_byte("srst_seen", 8'h01, srst_seen[7:0]);
        check_bit("lsb_first", 1'b0, lsb_first);
        check_byte("out_mode", 8'h01, out_mode);
        u_spi_host_model.settle();
        check_bit("boot_busy", 1'b0, boot_busy);
        // Soft reset with both copies set, then a zero write that must do nothing
        frame(1'b0, 15'h0000, 8'h24, 1'b0);
        frame(1'b0, 15'h0000, 8'h81, 1'b0);
        check_byte("srst_seen", 8'h02, srst_seen[7:0]);
        check_bit("addr_ascend", 1'b0, addr_ascend);
        u_spi_host_model.settle();
        frame(1'b0, 15'h0000, 8'h00, 1'b0);
        frame(1'b1, 15'h0000, 8'h00, 1'b0);
        check_byte("cfg_a", 8'h00, rd);
        // Falling step from address zero leaves every mapped region
        check_region("stepped", serial_cfg_pkg::REGION_NONE, region);
        check_byte("srst_seen", 8'h02, srst_seen[7:0]);
        test_done();
    end
endmodule : test_spi_config_register_map

bind serial_cfg_regs spi_config_register_map_chk #(.SRST_WAIT_CYC(SRST_WAIT_CYC)) u_chk (
    .clk(clk), .resetn(resetn), .sclk(sclk), .csn(csn), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .lsb_first(lsb_first), .addr_ascend(addr_ascend),
    .out_mode(out_mode), .soft_reset(soft_reset), .boot_busy(boot_busy), .region(region));
